// [src/bsiu_pkg.sv]
/*
  Constants, register map, command fields and opcodes of the bit and skip
  instruction unit. Assumes a single core clock and an Avalon-MM register host.
*/
`default_nettype none
package bsiu_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_POUT = 8'h0C;
  localparam logic [7:0] ADDR_PDIR = 8'h10;
  localparam logic [7:0] ADDR_PIN = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MEM = 8'h40;

  // Command word fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_BIT_LSB = 4;
  localparam int unsigned CMD_SRC_MEM = 7;
  localparam int unsigned CMD_IMM_LSB = 8;
  localparam int unsigned CMD_MADR_LSB = 16;

  // Flag and status bit positions
  localparam int unsigned FLG_Z = 0;
  localparam int unsigned FLG_C = 1;
  localparam int unsigned FLG_AC = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned STAT_SKIP = 0;
  localparam int unsigned STAT_SKIPPED = 1;

  // Reset values and constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_CLR_IO   = 4'h1,
    OP_SET_IO   = 4'h2,
    OP_CLR_MEM  = 4'h3,
    OP_SET_MEM  = 4'h4,
    OP_SWAP_C   = 4'h5,
    OP_CEQ      = 4'h6,
    OP_CNEQ     = 4'h7,
    OP_TLO_IO   = 4'h8,
    OP_THI_IO   = 4'h9,
    OP_TLO_MEM  = 4'hA,
    OP_THI_MEM  = 4'hB,
    OP_INC_ACC  = 4'hC,
    OP_DEC_ACC  = 4'hD,
    OP_INC_MEM  = 4'hE,
    OP_DEC_MEM  = 4'hF
  } bsiu_op_type;

endpackage
`default_nettype wire

// [src/bsiu_alu_if.sv]
/*
  Interface between the execution core and its 8-bit add/subtract unit.
  Assumes the unit is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface bsiu_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic sub;
  logic [7:0] res;
  logic [3:0] flags;
  modport core (output a, output b, output sub, input res, input flags);
  modport alu (input a, input b, input sub, output res, output flags);
endinterface
`default_nettype wire

// [src/bsiu_alu.sv]
/*
  8-bit adder/subtractor producing zero, carry, aux-carry and overflow.
  Assumes operands arrive over bsiu_alu_if; no state is held here.
*/
`timescale 1ns/10ps
`default_nettype none
module bsiu_alu import bsiu_pkg::*; (
  // Operands and result
  bsiu_alu_if.alu alu
);

  logic [7:0] b_eff;
  logic [8:0] full;
  logic [4:0] half;

  // Subtraction is a + ~b + 1; carry and aux-carry then read as borrows
  always_comb begin
    b_eff = alu.sub ? ~alu.b : alu.b;
    full = {1'b0, alu.a} + {1'b0, b_eff} + {8'h00, alu.sub};
    half = {1'b0, alu.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu.sub};
    alu.res = full[7:0];
    alu.flags = RST_FLAGS;
    alu.flags[FLG_Z] = (full[7:0] == RST_BYTE);
    alu.flags[FLG_C] = full[8] ^ alu.sub;
    alu.flags[FLG_AC] = half[4] ^ alu.sub;
    alu.flags[FLG_OV] = (alu.a[7] == b_eff[7]) && (full[7] != alu.a[7]);
  end

endmodule
`default_nettype wire

// [src/bsiu_top.sv]
/*
  Bit operation and conditional skip execution unit with its register file.
  Assumes an Avalon-MM host on CLK and an external pin pad that resolves
  PORT_PIN_OUT / PORT_PIN_OE_N onto the wire and returns its level.
*/
`timescale 1ns/10ps
`default_nettype none
module bsiu_top import bsiu_pkg::*; #(
  parameter int MEM_DEPTH = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Avalon-MM register slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Port pins
  input wire logic [7:0] PORT_PIN_IN,
  output logic [7:0] PORT_PIN_OUT,
  output logic [7:0] PORT_PIN_OE_N
);

  localparam int MA_W = $clog2(MEM_DEPTH);

  initial begin
    if (MEM_DEPTH < 2 || MEM_DEPTH > 16 || (1 << MA_W) != MEM_DEPTH) begin
      $error("MEM_DEPTH must be a power of two from 2 to 16");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, read data captured in the waited cycle

  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic reg_wr;
  logic cmd_fire;
  logic mem_hit;
  logic [3:0] bus_word;
  logic [31:0] wdata_be;

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA = rdata_q;
  assign reg_wr = AVS_WRITE & ack_q;
  assign cmd_fire = reg_wr && (AVS_ADDRESS == ADDR_CMD);
  assign bus_word = AVS_ADDRESS[5:2];
  assign mem_hit = (AVS_ADDRESS[7:6] == ADDR_MEM[7:6]) && (32'(bus_word) < MEM_DEPTH);

  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign wdata_be[i*8 +: 8] = AVS_BYTEENABLE[i] ? AVS_WRITEDATA[i*8 +: 8] : RST_BYTE;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Core state

  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [7:0] pout_q;
  logic [7:0] pout_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic skip_q;
  logic skip_d;
  logic skipped_q;
  logic skipped_d;
  logic [7:0] mem_q [0:MEM_DEPTH-1];
  logic [7:0] mem_d [0:MEM_DEPTH-1];
  logic [MA_W-1:0] last_idx_q;
  logic [MA_W-1:0] last_idx_d;
  logic [7:0] pin_m_q;
  logic [7:0] pin_s_q;

  // Decoded command
  bsiu_op_type cmd_op;
  logic [2:0] cmd_bit;
  logic [7:0] bit_mask;
  logic [7:0] cmd_imm;
  logic [MA_W-1:0] mem_idx;
  logic [7:0] mem_byte;
  logic [7:0] port_rd;
  logic port_bit;
  logic mem_bit;
  logic run;

  assign cmd_op = bsiu_op_type'(wdata_be[CMD_OP_LSB +: 4]);
  assign cmd_bit = wdata_be[CMD_BIT_LSB +: 3];
  assign bit_mask = ONE_BYTE << cmd_bit;
  assign cmd_imm = wdata_be[CMD_IMM_LSB +: 8];
  assign mem_idx = wdata_be[CMD_MADR_LSB +: MA_W];
  assign mem_byte = mem_q[mem_idx];
  // Output bits read back the latch, input bits the synchronised pin
  assign port_rd = (dir_q & pout_q) | (~dir_q & pin_s_q);
  assign port_bit = port_rd[cmd_bit];
  assign mem_bit = mem_byte[cmd_bit];
  assign run = cmd_fire & ~skip_q;

  // Direction 1 means output; enable is active low while driving
  assign PORT_PIN_OUT = pout_q;
  assign PORT_PIN_OE_N = ~dir_q;

  bsiu_alu_if alu_bus ();

  bsiu_alu u_alu (
    .alu (alu_bus)
  );

  always_comb begin
    alu_bus.a = acc_q;
    alu_bus.b = wdata_be[CMD_SRC_MEM] ? mem_byte : cmd_imm;
    alu_bus.sub = 1'b1;
    unique case (cmd_op)
      OP_INC_ACC: begin
        alu_bus.b = ONE_BYTE;
        alu_bus.sub = 1'b0;
      end
      OP_DEC_ACC: begin
        alu_bus.b = ONE_BYTE;
      end
      OP_INC_MEM: begin
        alu_bus.a = mem_byte;
        alu_bus.b = ONE_BYTE;
        alu_bus.sub = 1'b0;
      end
      OP_DEC_MEM: begin
        alu_bus.a = mem_byte;
        alu_bus.b = ONE_BYTE;
      end
      default: begin
        alu_bus.sub = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (req && !ack_q) begin
      rdata_d = RD_ZERO;
      if (mem_hit) begin
        rdata_d[7:0] = mem_q[bus_word[MA_W-1:0]];
      end else begin
        unique case (AVS_ADDRESS)
          ADDR_ACC: rdata_d[7:0] = acc_q;
          ADDR_FLAGS: rdata_d[3:0] = flags_q;
          ADDR_POUT: rdata_d[7:0] = pout_q;
          ADDR_PDIR: rdata_d[7:0] = dir_q;
          ADDR_PIN: rdata_d[7:0] = pin_s_q;
          ADDR_STAT: begin
            rdata_d[STAT_SKIP] = skip_q;
            rdata_d[STAT_SKIPPED] = skipped_q;
          end
          default: rdata_d = RD_ZERO;
        endcase
      end
    end
  end

  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    pout_d = pout_q;
    dir_d = dir_q;
    skip_d = skip_q;
    skipped_d = skipped_q;
    mem_d = mem_q;
    last_idx_d = cmd_fire ? mem_idx : last_idx_q;
    if (reg_wr && AVS_BYTEENABLE[0]) begin
      if (mem_hit) begin
        mem_d[bus_word[MA_W-1:0]] = AVS_WRITEDATA[7:0];
      end else begin
        unique case (AVS_ADDRESS)
          ADDR_ACC: acc_d = AVS_WRITEDATA[7:0];
          ADDR_FLAGS: flags_d = AVS_WRITEDATA[3:0];
          ADDR_POUT: pout_d = AVS_WRITEDATA[7:0];
          ADDR_PDIR: dir_d = AVS_WRITEDATA[7:0];
          default: acc_d = acc_q;
        endcase
      end
    end
    if (cmd_fire && skip_q) begin
      // Fetched but dropped: only the skip state moves
      skip_d = 1'b0;
      skipped_d = 1'b1;
    end else if (run) begin
      skipped_d = 1'b0;
      skip_d = 1'b0;
      unique case (cmd_op)
        OP_NOP: skip_d = 1'b0;
        OP_CLR_IO: pout_d = pout_q & ~bit_mask;
        OP_SET_IO: pout_d = pout_q | bit_mask;
        OP_CLR_MEM: mem_d[mem_idx] = mem_byte & ~bit_mask;
        OP_SET_MEM: mem_d[mem_idx] = mem_byte | bit_mask;
        OP_SWAP_C: begin
          // Output bit: carry goes out and old latch comes back
          // Input bit: latch kept, pin level loaded into carry
          flags_d[FLG_C] = port_bit;
          if (dir_q[cmd_bit]) begin
            pout_d[cmd_bit] = flags_q[FLG_C];
          end
        end
        OP_CEQ: begin
          flags_d = alu_bus.flags;
          skip_d = alu_bus.flags[FLG_Z];
        end
        OP_CNEQ: begin
          flags_d = alu_bus.flags;
          skip_d = ~alu_bus.flags[FLG_Z];
        end
        OP_TLO_IO: skip_d = ~port_bit;
        OP_THI_IO: skip_d = port_bit;
        OP_TLO_MEM: skip_d = ~mem_bit;
        OP_THI_MEM: skip_d = mem_bit;
        OP_INC_ACC, OP_DEC_ACC: begin
          acc_d = alu_bus.res;
          flags_d = alu_bus.flags;
          skip_d = alu_bus.flags[FLG_Z];
        end
        OP_INC_MEM, OP_DEC_MEM: begin
          mem_d[mem_idx] = alu_bus.res;
          flags_d = alu_bus.flags;
          skip_d = alu_bus.flags[FLG_Z];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      rdata_q <= RD_ZERO;
      acc_q <= RST_BYTE;
      flags_q <= RST_FLAGS;
      pout_q <= RST_BYTE;
      dir_q <= RST_DIR;
      skip_q <= 1'b0;
      skipped_q <= 1'b0;
      last_idx_q <= '0;
      pin_m_q <= RST_BYTE;
      pin_s_q <= RST_BYTE;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= RST_BYTE;
      end
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      pout_q <= pout_d;
      dir_q <= dir_d;
      skip_q <= skip_d;
      skipped_q <= skipped_d;
      last_idx_q <= last_idx_d;
      pin_m_q <= PORT_PIN_IN;
      pin_s_q <= pin_m_q;
      mem_q <= mem_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_clr_io_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_CLR_IO) |=> (pout_q == ($past(pout_q) & ~$past(bit_mask)))
      && (flags_q == $past(flags_q)))
    else $error("port bit clear wrong");

  a_set_io_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_SET_IO) |=> (pout_q == ($past(pout_q) | $past(bit_mask)))
      && $stable(flags_q))
    else $error("port bit set wrong");

  a_clr_mem_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_CLR_MEM) |=>
      (mem_q[last_idx_q] == ($past(mem_byte) & ~$past(bit_mask))) && $stable(flags_q))
    else $error("memory bit clear wrong");

  a_set_mem_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_SET_MEM) |=>
      (mem_q[last_idx_q] == ($past(mem_byte) | $past(bit_mask))) && $stable(flags_q))
    else $error("memory bit set wrong");

  a_swap_out_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_SWAP_C && dir_q[cmd_bit]) |=>
      ((pout_q & $past(bit_mask)) != RST_BYTE) == $past(flags_q[FLG_C]))
    else $error("swap did not drive carry out");

  a_swap_in_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_SWAP_C && !dir_q[cmd_bit]) |=>
      (flags_q[FLG_C] == $past(port_bit)) && $stable(pout_q) && $stable(acc_q))
    else $error("swap did not load pin into carry");

  a_cmp_eq_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_CEQ) |=>
      (skip_q == ($past(acc_q) == $past(alu_bus.b))) && $stable(acc_q))
    else $error("compare equal skip wrong");

  a_cmp_ne_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_CNEQ) |=>
      (skip_q == ($past(acc_q) != $past(alu_bus.b))) && $stable(acc_q))
    else $error("compare not equal skip wrong");

  a_cmp_flags: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && (cmd_op == OP_CEQ || cmd_op == OP_CNEQ)) |=>
      (flags_q[FLG_C] == ($past(acc_q) < $past(alu_bus.b)))
      && (flags_q[FLG_Z] == ($past(acc_q) == $past(alu_bus.b))))
    else $error("compare flags wrong");

  a_test_io_lo: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_TLO_IO) |=> (skip_q == !$past(port_bit)) && $stable(flags_q))
    else $error("port low test wrong");

  a_test_io_hi: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_THI_IO) |=> (skip_q == $past(port_bit)) && $stable(flags_q))
    else $error("port high test wrong");

  a_test_mem_lo: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_TLO_MEM) |=> (skip_q == !$past(mem_bit)) && $stable(flags_q))
    else $error("memory low test wrong");

  a_test_mem_hi: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_THI_MEM) |=> (skip_q == $past(mem_bit)) && $stable(flags_q))
    else $error("memory high test wrong");

  a_inc_acc_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_INC_ACC) |=> (acc_q == $past(acc_q) + ONE_BYTE)
      && (skip_q == (acc_q == RST_BYTE)) && (flags_q[FLG_Z] == skip_q))
    else $error("accumulator increment wrong");

  a_dec_acc_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_DEC_ACC) |=> (acc_q == $past(acc_q) - ONE_BYTE)
      && (skip_q == (acc_q == RST_BYTE)) && (flags_q[FLG_C] == ($past(acc_q) == RST_BYTE)))
    else $error("accumulator decrement wrong");

  a_inc_mem_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_INC_MEM) |=> (mem_q[last_idx_q] == $past(mem_byte) + ONE_BYTE)
      && (skip_q == (mem_q[last_idx_q] == RST_BYTE)) && $stable(acc_q))
    else $error("memory increment wrong");

  a_dec_mem_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
    (run && cmd_op == OP_DEC_MEM) |=> (mem_q[last_idx_q] == $past(mem_byte) - ONE_BYTE)
      && (skip_q == (mem_q[last_idx_q] == RST_BYTE)) && (flags_q[FLG_Z] == skip_q))
    else $error("memory decrement wrong");

  a_skip_discard: assert property (@(posedge CLK) disable iff (SYS_RST)
    (cmd_fire && skip_q) |=> !skip_q && skipped_q && $stable(acc_q) && $stable(flags_q)
      && $stable(pout_q) && (mem_q[last_idx_q] == $past(mem_byte)))
    else $error("skipped instruction had an effect");

endmodule
`default_nettype wire

// [verif/tb.sv]
/*
  Self-checking bench for the bit and skip instruction unit.
  Assumes bsiu_pkg and bsiu_top are compiled first. Commands and registers
  are reached only through the Avalon-MM slave; pins are driven directly.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import bsiu_pkg::*;;
  localparam int TIMEOUT = 20000;
  logic clk;
  logic sys_rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  int n_fail;
  int checked;
  int cycles;
  logic [31:0] exp;
  logic [7:0] a;
  logic [7:0] v;
  logic [7:0] r;
  logic skip;
  bsiu_op_type op;
  bsiu_op_type cmp_ops [6] = '{OP_CEQ, OP_CEQ, OP_CNEQ, OP_CNEQ, OP_CEQ, OP_CNEQ};
  logic [7:0] cmp_a [6] = '{8'h38, 8'h38, 8'h38, 8'h80, 8'h00, 8'h7F};
  logic [7:0] cmp_b [6] = '{8'h38, 8'h42, 8'h42, 8'h80, 8'h01, 8'hFF};
  bsiu_op_type tst_ops [4] = '{OP_TLO_IO, OP_THI_IO, OP_TLO_MEM, OP_THI_MEM};
  bsiu_op_type cnt_ops [4] = '{OP_INC_ACC, OP_DEC_ACC, OP_INC_MEM, OP_DEC_MEM};
  logic [7:0] cnt_v [7] = '{8'hFF, 8'h00, 8'h0F, 8'h7F, 8'h80, 8'h01, 8'h10};

  // Small memory keeps the index field short
  bsiu_top #(.MEM_DEPTH(4)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PORT_PIN_IN(pin_in), .PORT_PIN_OUT(pin_out), .PORT_PIN_OE_N(pin_oe_n)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] sub_flags(input logic [7:0] x, input logic [7:0] y);
    logic [7:0] d;
    d = x - y;
    return {28'h0, (x[7] != y[7]) && (d[7] != x[7]), x[3:0] < y[3:0], x < y, d == 8'h00};
  endfunction

  function automatic logic [31:0] add_flags(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, y};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    return {28'h0, (x[7] == y[7]) && (s[7] != x[7]), h[4], s[8], s[7:0] == 8'h00};
  endfunction

  function automatic logic [31:0] cmd(input logic [3:0] o, input logic [2:0] b,
                                      input logic m, input logic [7:0] imm,
                                      input logic [3:0] idx);
    return {12'h000, idx, imm, m, b, o};
  endfunction

  function automatic logic [7:0] maddr(input int i);
    return ADDR_MEM + 8'(i * 4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One idle edge before each request, so no signal is assigned twice per step
  task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] ad, input logic [31:0] ex);
    logic [31:0] d;
    bus_rd(ad, d);
    check(nm, d, ex);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus_wr(ad, d, 4'hF);
  endtask

  task automatic pins(input logic [7:0] p);
    @(posedge clk);
    pin_in <= p;
    repeat (3) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    pin_in = 8'h00;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset state, unmapped place, write-only command word, disabled lane
    chk_rd("acc rst", ADDR_ACC, 32'h0);
    chk_rd("flags rst", ADDR_FLAGS, 32'h0);
    chk_rd("stat rst", ADDR_STAT, 32'h0);
    check("oe_n rst", {24'h0, pin_oe_n}, 32'hFF);
    check("wait idle", {31'h0, avs_waitrequest}, 32'h0);
    wr(8'h30, 32'h0000_00FF);
    chk_rd("unmapped", 8'h30, 32'h0);
    bus_wr(ADDR_ACC, 32'h0000_0077, 4'hE);
    chk_rd("acc lane off", ADDR_ACC, 32'h0);
    chk_rd("cmd read", ADDR_CMD, 32'h0);
    // Port bit set and clear, every position
    wr(ADDR_PDIR, 32'hF0);
    wr(ADDR_POUT, 32'h5A);
    exp = 32'h5A;
    for (int b = 0; b < 8; b++) begin
      wr(ADDR_FLAGS, b[0] ? 32'hA : 32'h5);
      wr(ADDR_CMD, cmd(OP_SET_IO, 3'(b), 1'b0, 8'h00, 4'h0));
      exp[b] = 1'b1;
      chk_rd("port set", ADDR_POUT, exp);
      wr(ADDR_CMD, cmd(OP_CLR_IO, 3'(7 - b), 1'b0, 8'h00, 4'h0));
      exp[7 - b] = 1'b0;
      chk_rd("port clr", ADDR_POUT, exp);
      chk_rd("port flags", ADDR_FLAGS, b[0] ? 32'hA : 32'h5);
    end
    check("pin out", {24'h0, pin_out}, exp);
    check("oe_n", {24'h0, pin_oe_n}, 32'h0F);
    // Memory bit set and clear
    wr(maddr(2), 32'h3C);
    wr(ADDR_FLAGS, 32'hF);
    wr(ADDR_CMD, cmd(OP_SET_MEM, 3'd7, 1'b0, 8'h00, 4'h2));
    chk_rd("mem set", maddr(2), 32'hBC);
    wr(ADDR_CMD, cmd(OP_CLR_MEM, 3'd2, 1'b0, 8'h00, 4'h2));
    chk_rd("mem clr", maddr(2), 32'hB8);
    chk_rd("mem flags", ADDR_FLAGS, 32'hF);
    // Swap on an output bit: carry goes out, latch bit comes back
    wr(ADDR_PDIR, 32'h01);
    wr(ADDR_POUT, 32'h40);
    wr(ADDR_FLAGS, 32'h3);
    wr(ADDR_CMD, cmd(OP_SWAP_C, 3'd0, 1'b0, 8'h00, 4'h0));
    chk_rd("swap out", ADDR_POUT, 32'h41);
    chk_rd("swap out flags", ADDR_FLAGS, 32'h1);
    check("swap pin", {24'h0, pin_out}, 32'h41);
    // Swap on an input bit: pin level into carry, serial receive of 1 then 0
    pins(8'h08);
    wr(ADDR_FLAGS, 32'hD);
    wr(ADDR_CMD, cmd(OP_SWAP_C, 3'd3, 1'b0, 8'h00, 4'h0));
    chk_rd("swap in 1", ADDR_FLAGS, 32'hF);
    pins(8'hF7);
    wr(ADDR_CMD, cmd(OP_SWAP_C, 3'd3, 1'b0, 8'h00, 4'h0));
    chk_rd("swap in 0", ADDR_FLAGS, 32'hD);
    chk_rd("swap in latch", ADDR_POUT, 32'h41);
    // Compare and skip; the following increment must vanish when skipped
    for (int i = 0; i < 6; i++) begin
      op = cmp_ops[i];
      a = cmp_a[i];
      skip = (op == OP_CEQ) == (a == cmp_b[i]);
      wr(ADDR_ACC, {24'h0, a});
      wr(ADDR_FLAGS, 32'h0);
      wr(maddr(1), {24'h0, cmp_b[i]});
      wr(ADDR_CMD, cmd(op, 3'd0, i[0], i[0] ? 8'h00 : cmp_b[i], 4'h1));
      chk_rd("cmp acc", ADDR_ACC, {24'h0, a});
      chk_rd("cmp flags", ADDR_FLAGS, sub_flags(a, cmp_b[i]));
      chk_rd("cmp skip", ADDR_STAT, {31'h0, skip});
      wr(ADDR_CMD, cmd(OP_INC_ACC, 3'd0, 1'b0, 8'h00, 4'h0));
      chk_rd("after cmp acc", ADDR_ACC, {24'h0, skip ? a : a + 8'h01});
      chk_rd("after cmp stat", ADDR_STAT, skip ? 32'h2 : 32'h0);
    end
    // Bit tests: port value A5 from latch (low nibble) and pins (high nibble)
    wr(ADDR_PDIR, 32'h0F);
    wr(ADDR_POUT, 32'h05);
    pins(8'hA0);
    chk_rd("pin reg", ADDR_PIN, 32'hA0);
    chk_rd("dir reg", ADDR_PDIR, 32'h0F);
    wr(maddr(0), 32'hA5);
    for (int k = 0; k < 32; k++) begin
      op = tst_ops[k / 8];
      v = 8'hA5;
      skip = v[k % 8];
      skip = (skip == op[0]);
      wr(ADDR_FLAGS, 32'h5);
      wr(ADDR_CMD, cmd(op, 3'(k % 8), 1'b0, 8'h00, 4'h0));
      chk_rd("test skip", ADDR_STAT, {31'h0, skip});
      wr(ADDR_CMD, cmd(OP_SET_MEM, 3'd6, 1'b0, 8'h00, 4'h0));
      chk_rd("test mem", maddr(0), skip ? 32'hA5 : 32'hE5);
      chk_rd("test flags", ADDR_FLAGS, 32'h5);
      wr(maddr(0), 32'hA5);
    end
    // Increment and decrement with skip on zero, accumulator and memory
    for (int k = 0; k < 28; k++) begin
      op = cnt_ops[k / 7];
      v = cnt_v[k % 7];
      r = op[0] ? v - 8'h01 : v + 8'h01;
      a = op[1] ? maddr(3) : ADDR_ACC;
      exp = op[0] ? sub_flags(v, 8'h01) : add_flags(v, 8'h01);
      skip = (r == 8'h00);
      wr(a, {24'h0, v});
      wr(ADDR_FLAGS, 32'h0);
      wr(ADDR_CMD, cmd(op, 3'h0, 1'b0, 8'h00, 4'h3));
      chk_rd("count value", a, {24'h0, r});
      chk_rd("count flags", ADDR_FLAGS, exp);
      chk_rd("count skip", ADDR_STAT, {31'h0, skip});
      wr(ADDR_CMD, cmd(OP_NOP, 3'd0, 1'b0, 8'h00, 4'h0));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
